// ==== core/pwm_cfg.svh ====
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ==========================================================
// register offsets
`define ADDR_PERIOD_A 8'h00
`define ADDR_PULSE_HI_A 8'h01
`define ADDR_PULSE_LO_A 8'h02
`define ADDR_PERIOD_B 8'h03
`define ADDR_PULSE_HI_B 8'h04
`define ADDR_PULSE_LO_B 8'h05
`define ADDR_DUTY_A 8'h07
`define ADDR_DUTY_B 8'h08

// ==========================================================
// reset values
`define RST_DUTY 8'h00
`define RST_PERIOD 8'h00
`define RST_PULSE_HI 8'h00
`define RST_PULSE 11'h000

// ==========================================================
// field positions in the pulse high byte
`define PULSE_HI_CNT_MSB 2
`define PULSE_HI_DIR_BIT 6
`define PULSE_HI_DBL_BIT 7

`endif

// ==== core/pwm_pkg.sv ====
package pwm_pkg;

  // ==========================================================
  // types
  typedef logic [7:0] byte_t;
  typedef logic [10:0] pulse_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } chan_state_t;

endpackage

// ==== core/pwm_chan_if.sv ====
`timescale 1ns/1ps
interface pwm_chan_if;
  import pwm_pkg::*;

  byte_t period;
  byte_t duty;
  logic run;
  logic wrap;
  logic drive;

  modport chan (input period, input duty, input run, output wrap, output drive);
  modport ctrl (output period, output duty, output run, input wrap, input drive);
endinterface

// ==== core/duty_pwm_channel.sv ====
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module duty_pwm_channel
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // settings and waveform
  pwm_chan_if.chan chan
);

  // ==========================================================
  // state
  chan_state_t st_r, st_nxt;
  byte_t cnt_r, cnt_nxt;
  byte_t hi_len;
  logic drive_r, drive_nxt;
  logic wrap_r, wrap_nxt;

  // ==========================================================
  // next state
  always_comb begin
    // zero setting gives floor half high, odd period low one longer
    hi_len = (chan.duty == `RST_DUTY) ? (chan.period >> 1) : chan.duty;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    drive_nxt = 1'b0;
    wrap_nxt = 1'b0;
    if (!chan.run || chan.period == `RST_PERIOD) begin
      st_nxt = ST_IDLE;
      cnt_nxt = 8'h00;
    end else begin
      case (st_r)
        ST_IDLE: begin
          st_nxt = ST_RUN;
          cnt_nxt = 8'h00;
        end
        ST_RUN: begin
          if (cnt_r >= chan.period - 8'h01) begin
            cnt_nxt = 8'h00;
            wrap_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          cnt_nxt = 8'h00;
        end
      endcase
      drive_nxt = (cnt_nxt < hi_len);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      drive_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      drive_r <= drive_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  assign chan.drive = drive_r;
  assign chan.wrap = wrap_r;

endmodule // duty_pwm_channel

// ==== core/dual_duty_pwm.sv ====
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module dual_duty_pwm
  import pwm_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // power-down pin
  input wire logic i_power_down_n,
  // register access from the serial slave
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // driver outputs
  output logic [NUM_CH-1:0] o_drv,
  output logic [NUM_CH-1:0] o_dir
);

  // ==========================================================
  // power-down synchroniser
  logic pd_meta_r, pd_sync_r;
  logic pd_active;

  // pin is asynchronous, two flops before any logic
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_meta_r <= 1'b0;
      pd_sync_r <= 1'b0;
    end else begin
      pd_meta_r <= i_power_down_n;
      pd_sync_r <= pd_meta_r;
    end
  end

  assign pd_active = !pd_sync_r;

  // ==========================================================
  // per-channel registers and generators
  byte_t rd_val [NUM_CH];
  logic [NUM_CH-1:0] rd_hit;
  logic [NUM_CH-1:0] drv_nxt;
  logic [NUM_CH-1:0] dir_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam byte_t A_PER = (ch == 0) ? `ADDR_PERIOD_A : `ADDR_PERIOD_B;
      localparam byte_t A_HI = (ch == 0) ? `ADDR_PULSE_HI_A : `ADDR_PULSE_HI_B;
      localparam byte_t A_LO = (ch == 0) ? `ADDR_PULSE_LO_A : `ADDR_PULSE_LO_B;
      localparam byte_t A_DUTY = (ch == 0) ? `ADDR_DUTY_A : `ADDR_DUTY_B;

      byte_t period_r, period_nxt;
      byte_t duty_r, duty_nxt;
      byte_t pulse_hi_r, pulse_hi_nxt;
      pulse_t remain_r, remain_nxt;
      logic wr_per, wr_hi, wr_lo, wr_duty;
      logic last_wrap;
      logic hit;
      byte_t val;

      pwm_chan_if chan_if ();

      // ==========================================================
      // write strobes
      assign wr_per = i_reg_wr && (i_reg_addr == A_PER);
      assign wr_hi = i_reg_wr && (i_reg_addr == A_HI);
      assign wr_lo = i_reg_wr && (i_reg_addr == A_LO);
      assign wr_duty = i_reg_wr && (i_reg_addr == A_DUTY);

      // ==========================================================
      // settings, cleared while powered down
      always_comb begin
        period_nxt = period_r;
        duty_nxt = duty_r;
        pulse_hi_nxt = pulse_hi_r;
        if (pd_active) begin
          duty_nxt = `RST_DUTY;
          period_nxt = `RST_PERIOD;
          pulse_hi_nxt = `RST_PULSE_HI;
        end else begin
          if (wr_per) begin
            period_nxt = i_reg_wdata;
          end
          if (wr_hi) begin
            pulse_hi_nxt = i_reg_wdata;
          end
          if (wr_duty) begin
            duty_nxt = i_reg_wdata;
          end
        end
      end

      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          period_r <= `RST_PERIOD;
          duty_r <= `RST_DUTY;
          pulse_hi_r <= `RST_PULSE_HI;
        end else begin
          period_r <= period_nxt;
          duty_r <= duty_nxt;
          pulse_hi_r <= pulse_hi_nxt;
        end
      end

      // ==========================================================
      // remaining pulse count, lo byte write wins over a wrap
      always_comb begin
        remain_nxt = remain_r;
        if (chan_if.wrap && remain_r != `RST_PULSE) begin
          remain_nxt = remain_r - pulse_t'(1);
        end
        if (pd_active) begin
          remain_nxt = `RST_PULSE;
        end else if (wr_lo) begin
          // zero stops at once, even mid-sequence
          remain_nxt = {pulse_hi_r[`PULSE_HI_CNT_MSB:0], i_reg_wdata};
        end
      end

      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          remain_r <= `RST_PULSE;
        end else begin
          remain_r <= remain_nxt;
        end
      end

      // ==========================================================
      // waveform generator
      assign chan_if.period = period_r;
      assign chan_if.duty = duty_r;
      assign chan_if.run = (remain_r != `RST_PULSE) && !pd_active;

      duty_pwm_channel u_chan (
        .i_clk_sys (i_clk_sys),
        .i_nrst (i_nrst),
        .chan (chan_if.chan)
      );

      // final wrap would otherwise leak one extra high cycle
      assign last_wrap = chan_if.wrap && (remain_r == pulse_t'(1));
      assign drv_nxt[ch] = chan_if.drive && chan_if.run && !last_wrap;
      assign dir_nxt[ch] = pulse_hi_r[`PULSE_HI_DIR_BIT];

      // ==========================================================
      // read back
      always_comb begin
        hit = 1'b1;
        if (i_reg_addr == A_PER) begin
          val = period_r;
        end else if (i_reg_addr == A_HI) begin
          val = {pulse_hi_r[`PULSE_HI_DBL_BIT:`PULSE_HI_CNT_MSB+1],
                 remain_r[$bits(pulse_t)-1:$bits(byte_t)]};
        end else if (i_reg_addr == A_LO) begin
          val = remain_r[$bits(byte_t)-1:0];
        end else if (i_reg_addr == A_DUTY) begin
          val = duty_r;
        end else begin
          hit = 1'b0;
          val = 8'h00;
        end
      end

      assign rd_hit[ch] = hit;
      assign rd_val[ch] = val;
    end
  endgenerate

  // ==========================================================
  // read mux
  byte_t rdata_r, rdata_nxt;
  logic [NUM_CH-1:0] drv_r, dir_r;

  // address windows never overlap, unmapped reads as zero
  always_comb begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (rd_hit[i]) begin
        rdata_nxt = rd_val[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // driver output registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      drv_r <= '0;
      dir_r <= '0;
    end else begin
      drv_r <= drv_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_drv = drv_r;
  assign o_dir = dir_r;

endmodule // dual_duty_pwm

// ==== sim/drive_stage_model.sv ====
`timescale 1ns/1ps
// ==========
// half-bridge load, counts drive pulses
module drive_stage_model (
  input wire logic i_clk_sys,
  input wire logic i_clr,
  input wire logic [1:0] i_drv,
  output logic [11:0] o_pulses [2]
);
  logic [1:0] prev_r;
  always_ff @(posedge i_clk_sys) begin
    prev_r <= i_drv;
    for (int c = 0; c < 2; c++)
      o_pulses[c] <= i_clr ? 12'h0 : o_pulses[c] + 12'(i_drv[c] & ~prev_r[c]);
  end
endmodule // drive_stage_model

// ==== sim/dual_duty_pwm_asserts.sv ====
`timescale 1ns/1ps
// ==========
// drive timing checks
module dual_duty_pwm_asserts #(
  parameter int NUM_CH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_power_down_n,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [NUM_CH-1:0] o_drv,
  input wire logic [NUM_CH-1:0] o_dir
);
  logic [8:0] per_r [2], duty_r [2], hc_r [2], lc_r [2], hx [2];
  logic [2:0] hi_r [2];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  always_comb
    for (int c = 0; c < 2; c++)
      hx[c] = (duty_r[c] == 9'h0) ? per_r[c] >> 1 : duty_r[c];
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    for (int c = 0; c < 2; c++)
      if (!i_nrst) begin
        per_r[c] <= 9'h0;
        duty_r[c] <= 9'h0;
        hi_r[c] <= 3'h0;
        hc_r[c] <= 9'h0;
        lc_r[c] <= 9'h1ff; // long low until the first high
      end else begin
        if (i_reg_wr && i_reg_addr == 8'(3 * c)) per_r[c] <= {1'b0, i_reg_wdata};
        if (i_reg_wr && i_reg_addr == 8'(3 * c + 1)) hi_r[c] <= i_reg_wdata[2:0];
        if (i_reg_wr && i_reg_addr == 8'(7 + c)) duty_r[c] <= {1'b0, i_reg_wdata};
        hc_r[c] <= o_drv[c] ? hc_r[c] + 9'h1 : 9'h0;
        lc_r[c] <= o_drv[c] ? 9'h0 : lc_r[c] + 9'(lc_r[c] != 9'h1ff);
      end
  a_pd_drive_low: assert property (!i_power_down_n [*5] |-> o_drv == '0)
    else $error("drive in power-down");
  a_pd_dir_low: assert property (!i_power_down_n [*5] |-> o_dir == '0)
    else $error("dir in power-down");
  a_high_width_a: assert property ($fell(o_drv[0]) |-> hc_r[0] == hx[0])
    else $error("a high width");
  a_high_width_b: assert property ($fell(o_drv[1]) |-> hc_r[1] == hx[1])
    else $error("b high width");
  a_low_width_a: assert property ($rose(o_drv[0]) && lc_r[0] <= per_r[0]
    |-> lc_r[0] == per_r[0] - hx[0]) else $error("a low width");
  a_low_width_b: assert property ($rose(o_drv[1]) && lc_r[1] <= per_r[1]
    |-> lc_r[1] == per_r[1] - hx[1]) else $error("b low width");
  a_stop_a: assert property (i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata == 8'h00
    && hi_r[0] == 3'h0 |-> ##2 !o_drv[0] [*8]) else $error("a not stopped");
  a_stop_b: assert property (i_reg_wr && i_reg_addr == 8'h05 && i_reg_wdata == 8'h00
    && hi_r[1] == 3'h0 |-> ##2 !o_drv[1] [*8]) else $error("b not stopped");
endmodule // dual_duty_pwm_asserts
bind dual_duty_pwm dual_duty_pwm_asserts #(.NUM_CH(NUM_CH)) i_dual_duty_pwm_asserts (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_power_down_n(i_power_down_n),
  .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_drv(o_drv), .o_dir(o_dir));

// ==== sim/dual_duty_pwm_test.sv ====
`timescale 1ns/1ps
// ==========
// testbench
module dual_duty_pwm_test;
  import pwm_pkg::*;
  logic i_clk_sys, i_nrst, i_power_down_n, i_reg_wr, clr;
  byte_t i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [1:0] o_drv, o_dir;
  logic [11:0] pulses [2];
  int err_total, comparisons;
  dual_duty_pwm i_dual_duty_pwm (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_power_down_n(i_power_down_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_drv(o_drv), .o_dir(o_dir));
  drive_stage_model i_drive_stage_model (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_drv(o_drv),
    .o_pulses(pulses));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] got);
    comparisons++;
    if (got !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", what, e, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    tick(1);
    i_reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input byte_t a, input byte_t e);
    i_reg_addr <= a;
    tick(2);
    chk("rdata", 12'(e), 12'(o_reg_rdata));
  endtask
  task automatic go(input int c, input byte_t p, input byte_t d, input byte_t h, input byte_t l);
    wr(8'(3 * c), p);
    wr(8'(7 + c), d);
    wr(8'(3 * c + 1), h);
    wr(8'(3 * c + 2), l);
  endtask
  task automatic fall(input int c);
    int n = 0;
    while (o_drv[c] !== 1'b1 && n < 900) begin
      tick(1);
      n++;
    end
    while (o_drv[c] !== 1'b0 && n < 900) begin
      tick(1);
      n++;
    end
    if (n >= 900) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic t_reset();
    rd(8'h07, 8'h00);
    wr(8'h07, 8'h5a);
    rd(8'h07, 8'h5a);
    rd(8'h08, 8'h00);
  endtask
  task automatic t_burst();
    clr <= 1'b0;
    go(0, 8'h85, 8'h00, 8'h00, 8'h03);
    go(1, 8'h64, 8'h16, 8'h00, 8'h04);
    tick(600);
    chk("pulses a", 12'h003, pulses[0]);
    chk("pulses b", 12'h004, pulses[1]);
  endtask
  task automatic t_stop();
    logic [11:0] p;
    go(0, 8'h64, 8'h0d, 8'h44, 8'h01);
    fall(0);
    chk("dir a", 12'h001, 12'(o_dir[0]));
    rd(8'h01, 8'h44);
    rd(8'h02, 8'h01);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    p = pulses[0];
    tick(300);
    chk("pulses stop", p, pulses[0]);
  endtask
  task automatic t_pd();
    go(1, 8'h43, 8'h21, 8'h40, 8'h10);
    fall(1);
    i_power_down_n <= 1'b0;
    tick(200);
    chk("drv pd", 12'h000, 12'(o_drv));
    chk("dir pd", 12'h000, 12'(o_dir));
    i_power_down_n <= 1'b1;
    tick(4);
    rd(8'h08, 8'h00);
    rd(8'h07, 8'h00);
  endtask
  initial begin
    i_nrst = 1'b0;
    i_power_down_n = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    clr = 1'b1;
    err_total = 0;
    comparisons = 0;
    tick(10);
    i_nrst <= 1'b1;
    tick(3);
    t_reset();
    t_burst();
    t_stop();
    t_pd();
    test_done();
  end
endmodule // dual_duty_pwm_test
